// *** dbc_pkg.sv ***
package dbc_pkg;
	// --------------------------------------------------------------
	// Register offsets on the debug link (write-only space).
	// --------------------------------------------------------------
	localparam logic [6:0] OFS_MATCH_LAST = 7'h0E;
	localparam logic [6:0] OFS_BREAK_CONTROL = 7'h10;
	localparam logic [6:0] OFS_WRITE_DATA_UPPER = 7'h13;
	localparam logic [6:0] OFS_WRITE_DATA_HIGH = 7'h14;
	localparam logic [6:0] OFS_WRITE_DATA_LOW = 7'h15;
	localparam logic [6:0] OFS_CPU_ACCESS_COMMAND = 7'h16;
	localparam logic [1:0] MATCH_BYTE_LOW = 2'h0;
	localparam logic [1:0] MATCH_BYTE_HIGH = 2'h1;
	localparam logic [1:0] MATCH_BYTE_UPPER = 2'h2;

	// --------------------------------------------------------------
	// Break control fields and reset value.
	// --------------------------------------------------------------
	localparam int BIT_BREAK_NEXT = 7;
	localparam int BIT_MATCH_ENABLE_LSB = 3;
	localparam int BIT_MATCH1_PAGE = 2;
	localparam int BIT_MATCH0_PAGE = 1;
	localparam int BIT_SINGLE_STEP = 0;
	localparam logic [7:0] BREAK_CONTROL_RESET = 8'h00;

	// --------------------------------------------------------------
	// Command codes.
	// --------------------------------------------------------------
	localparam logic [7:0] CMD_READ_FIRST = 8'h00;
	localparam logic [7:0] CMD_READ_LAST = 8'h07;
	localparam logic [7:0] CMD_SET_LONG = 8'h08;
	localparam logic [7:0] CMD_WRITE_FIRST = 8'h80;
	localparam logic [7:0] CMD_WRITE_LAST = 8'h87;
	localparam logic [7:0] CMD_RESERVED_88 = 8'h88;
	localparam logic [2:0] SEL_STACK_POINTER = 3'h6;
endpackage : dbc_pkg

// *** dbc_debug_break.sv ***
// Contract
// (RULE1) Break-next set halts the CPU before the next instruction's first opcode.
// (RULE2) Clock and data pins low during reset set break-next after reset.
// (RULE3) Each enabled match set breaks when the 24-bit address equals it.
// (RULE4) Matches break at instruction start, else at end of current instruction.
// (RULE5) A match sets break-next; the master clears it to resume.
// (RULE6) Match 1 page mode compares address bits 23 to 8 only.
// (RULE7) Match 0 page mode compares only the upper two address bytes.
// (RULE8) Single step breaks after every executed instruction.
// (RULE9) Write-data bytes form a 24-bit operand; short operands use low bytes.
// (RULE10) Command register follows write data so one block write suffices.
// (RULE11) A command write executes immediately with no further trigger.
// (RULE12) Reads fill the read-result bytes; writes take the write-data bytes.
// (RULE13) Codes 00 to 05 read base/flags/acc, BC, DE, HL, IX, IY.
// (RULE14) Codes 80 to 85 write those triples in the same byte order.
// (RULE15) Codes 06 and 86 access long or short stack pointer by mode.
// (RULE16) Codes 07 and 87 read and write the 24-bit program counter.
// (RULE17) Code 08 sets long-address mode; code 88 does nothing.
// (RULE18) Compare address is 24-bit in long mode, else base byte plus 16 bits.
// (RULE19) Four write-only match sets sit at 00h to 0Eh, low/high/upper.
// (RULE20) Reserved or unknown codes change no CPU or read-result register.
// (RULE21) While break holds, the CPU stays suspended and commands act on it.
module dbc_debug_break
	import dbc_pkg::*;
#(
	parameter int MATCH_SETS = 4
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic link_clk,
	input wire logic link_wr_en,
	input wire logic [6:0] link_wr_addr,
	input wire logic [7:0] link_wr_data,
	input wire logic debug_serial_clock_pin,
	input wire logic debug_serial_data_pin,
	input wire logic [23:0] cpu_addr,
	input wire logic cpu_addr_valid,
	input wire logic cpu_instr_start,
	input wire logic cpu_instr_end,
	input wire logic long_address_mode,
	input wire logic [7:0] memory_base_byte,
	input wire logic [23:0] cpu_reg_rdata,
	output logic cpu_halt,
	output logic cpu_reg_rd,
	output logic cpu_reg_wr,
	output logic [2:0] cpu_reg_sel,
	output logic cpu_reg_long_sp,
	output logic [23:0] cpu_reg_wdata,
	output logic cpu_set_long_mode,
	output logic [7:0] read_result_upper,
	output logic [7:0] read_result_high,
	output logic [7:0] read_result_low
);
	// --------------------------------------------------------------
	// Link domain: capture each written byte and flip a toggle.
	// --------------------------------------------------------------
	logic [1:0] lk_rst_q;
	logic [6:0] lk_addr_q, lk_addr_d;
	logic [7:0] lk_data_q, lk_data_d;
	logic lk_tgl_q, lk_tgl_d;

	// Address and data stay put until the next byte, which is at least nine link clocks later.
	always_comb begin
		lk_addr_d = lk_addr_q;
		lk_data_d = lk_data_q;
		lk_tgl_d = lk_tgl_q;
		if (lk_rst_q[1]) begin
			lk_tgl_d = 1'b0;
		end else if (link_wr_en) begin
			lk_addr_d = link_wr_addr;
			lk_data_d = link_wr_data;
			lk_tgl_d = ~lk_tgl_q;
		end
	end

	always_ff @(posedge link_clk) begin
		lk_rst_q <= {lk_rst_q[0], srst};
		lk_addr_q <= lk_addr_d;
		lk_data_q <= lk_data_d;
		lk_tgl_q <= lk_tgl_d;
	end

	// --------------------------------------------------------------
	// Core domain: synchronisers and write event.
	// --------------------------------------------------------------
	logic [1:0] tgl_sync_q, pclk_sync_q, pdat_sync_q;
	logic seen_q;
	logic wr_evt;
	logic [6:0] wa;
	logic [7:0] wd;

	always_ff @(posedge core_clk) begin
		tgl_sync_q <= {tgl_sync_q[0], lk_tgl_q};
		pclk_sync_q <= {pclk_sync_q[0], debug_serial_clock_pin};
		pdat_sync_q <= {pdat_sync_q[0], debug_serial_data_pin};
		seen_q <= srst ? 1'b0 : tgl_sync_q[1];
	end

	// The held link registers are stable once the toggle has crossed.
	assign wr_evt = (tgl_sync_q[1] ^ seen_q) & ~srst;
	assign wa = lk_addr_q;
	assign wd = lk_data_q;

	// --------------------------------------------------------------
	// Match registers and compare.
	// --------------------------------------------------------------
	logic [23:0] match_q [MATCH_SETS], match_d [MATCH_SETS];
	logic [MATCH_SETS-1:0] hit;
	logic [23:0] cmp_addr;
	logic [7:0] brk_q, brk_d;

	// Compatibility mode prefixes the base byte to the 16-bit address.
	assign cmp_addr = long_address_mode ? cpu_addr : {memory_base_byte, cpu_addr[15:0]}; // see RULE18

	for (genvar i = 0; i < MATCH_SETS; i++) begin : g_match
		logic page;
		assign page = (i == 0) ? brk_q[BIT_MATCH0_PAGE] : (i == 1) ? brk_q[BIT_MATCH1_PAGE] : 1'b0;

		// Byte lanes: low, high, upper within each group of four offsets.
		always_comb begin
			match_d[i] = match_q[i];
			if (srst) begin
				match_d[i] = 24'h000000;
			end else if (wr_evt && wa <= OFS_MATCH_LAST && wa[3:2] == 2'(i)) begin // see RULE19
				case (wa[1:0])
					MATCH_BYTE_LOW: match_d[i][7:0] = wd;
					MATCH_BYTE_HIGH: match_d[i][15:8] = wd;
					MATCH_BYTE_UPPER: match_d[i][23:16] = wd;
					default: match_d[i] = match_q[i];
				endcase
			end
		end

		always_ff @(posedge core_clk) begin
			match_q[i] <= match_d[i];
		end

		// Page mode drops the low byte from the compare.
		assign hit[i] = cpu_addr_valid && brk_q[BIT_MATCH_ENABLE_LSB + i] // see RULE3
			&& cmp_addr[23:8] == match_q[i][23:8]
			&& (page || cmp_addr[7:0] == match_q[i][7:0]); // see RULE6 see RULE7
	end

	// --------------------------------------------------------------
	// Break control.
	// --------------------------------------------------------------
	logic pend_q, pend_d;
	logic late, hw_set;

	// A hit on a non-opcode fetch waits for the instruction to finish.
	assign late = |hit & ~cpu_instr_start;
	assign hw_set = (|hit & cpu_instr_start) // see RULE1 see RULE4
		| ((pend_q | late) & cpu_instr_end) // see RULE4
		| (brk_q[BIT_SINGLE_STEP] & cpu_instr_end); // see RULE8

	// Hardware setting break-next wins over a clearing write in the same cycle.
	always_comb begin
		brk_d = brk_q;
		pend_d = (pend_q | late) & ~cpu_instr_end;
		if (srst) begin
			brk_d = BREAK_CONTROL_RESET;
			brk_d[BIT_BREAK_NEXT] = ~pclk_sync_q[1] & ~pdat_sync_q[1]; // see RULE2
			pend_d = 1'b0;
		end else begin
			if (wr_evt && wa == OFS_BREAK_CONTROL) begin
				brk_d = wd;
			end
			if (hw_set) begin
				brk_d[BIT_BREAK_NEXT] = 1'b1; // see RULE5
			end
		end
	end

	always_ff @(posedge core_clk) begin
		brk_q <= brk_d;
		pend_q <= pend_d;
	end

	// The CPU halts at its next boundary while break-next holds.
	assign cpu_halt = brk_q[BIT_BREAK_NEXT]; // see RULE1 see RULE21

	// --------------------------------------------------------------
	// Write data and command execution.
	// --------------------------------------------------------------
	logic [23:0] wdat_q, wdat_d;
	logic rd_q, rd_d, wr_q, wr_d, setl_q, setl_d, cap_q, cap_d, lsp_q, lsp_d;
	logic [2:0] sel_q, sel_d;
	logic [23:0] res_q, res_d;
	logic cmd_evt;

	assign cmd_evt = wr_evt && wa == OFS_CPU_ACCESS_COMMAND; // see RULE10 see RULE11

	// Commands act in the cycle after the byte crosses; the CPU answers reads the same cycle.
	always_comb begin
		wdat_d = wdat_q;
		rd_d = 1'b0;
		wr_d = 1'b0;
		setl_d = 1'b0;
		sel_d = sel_q;
		lsp_d = lsp_q;
		cap_d = rd_q;
		res_d = rd_q ? cpu_reg_rdata : res_q; // see RULE12
		if (srst) begin
			wdat_d = 24'h000000;
			sel_d = 3'h0;
			lsp_d = 1'b0;
			cap_d = 1'b0;
			res_d = 24'h000000;
		end else if (wr_evt) begin
			case (wa)
				OFS_WRITE_DATA_UPPER: wdat_d[23:16] = wd; // see RULE9
				OFS_WRITE_DATA_HIGH: wdat_d[15:8] = wd;
				OFS_WRITE_DATA_LOW: wdat_d[7:0] = wd;
				OFS_CPU_ACCESS_COMMAND: begin
					lsp_d = long_address_mode; // see RULE15
					if (wd <= CMD_READ_LAST) begin
						rd_d = 1'b1; // see RULE13 see RULE16
						sel_d = wd[2:0];
					end else if (wd >= CMD_WRITE_FIRST && wd <= CMD_WRITE_LAST) begin
						wr_d = 1'b1; // see RULE14 see RULE16
						sel_d = wd[2:0];
					end else if (wd == CMD_SET_LONG) begin
						setl_d = 1'b1; // see RULE17
					end
				end
				default: wdat_d = wdat_q;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		wdat_q <= wdat_d;
		rd_q <= rd_d;
		wr_q <= wr_d;
		setl_q <= setl_d;
		sel_q <= sel_d;
		lsp_q <= lsp_d;
		cap_q <= cap_d;
		res_q <= res_d;
	end

	assign cpu_reg_rd = rd_q;
	assign cpu_reg_wr = wr_q;
	assign cpu_reg_sel = sel_q;
	assign cpu_reg_long_sp = lsp_q;
	assign cpu_reg_wdata = wdat_q;
	assign cpu_set_long_mode = setl_q;
	assign read_result_upper = res_q[23:16];
	assign read_result_high = res_q[15:8];
	assign read_result_low = res_q[7:0];

	// --------------------------------------------------------------
	// Assertions.
	// --------------------------------------------------------------
	sequence s_read_cmd;
		cmd_evt && wd <= CMD_READ_LAST;
	endsequence
	sequence s_read_done;
		rd_q ##1 cap_q;
	endsequence

	a_break_holds: assert property (@(posedge core_clk) disable iff (srst) // see RULE5
		cpu_halt && !(wr_evt && wa == OFS_BREAK_CONTROL) |=> cpu_halt)
		else $error("break released without a write");
	a_step_break: assert property (@(posedge core_clk) disable iff (srst) // see RULE8
		brk_q[BIT_SINGLE_STEP] && cpu_instr_end |=> cpu_halt)
		else $error("single step did not break");
	a_strap_break: assert property (@(posedge core_clk) // see RULE2
		srst && !pclk_sync_q[1] && !pdat_sync_q[1] |=> cpu_halt)
		else $error("strap did not set break");
	a_match_first: assert property (@(posedge core_clk) disable iff (srst) // see RULE3
		|hit && cpu_instr_start |=> cpu_halt)
		else $error("match on opcode did not break");
	a_match_late: assert property (@(posedge core_clk) disable iff (srst) // see RULE4
		(late || pend_q) && cpu_instr_end |=> cpu_halt)
		else $error("late match did not break at end");
	a_late_pending: assert property (@(posedge core_clk) disable iff (srst) // see RULE4
		late && !cpu_instr_end |=> pend_q)
		else $error("late match not held until the end");
	a_page_match: assert property (@(posedge core_clk) disable iff (srst) // see RULE6
		cpu_addr_valid && cpu_instr_start && brk_q[BIT_MATCH_ENABLE_LSB + 1] && brk_q[BIT_MATCH1_PAGE]
		&& cmp_addr[23:8] == match_q[1][23:8] |=> cpu_halt)
		else $error("page match missed");
	a_read_result: assert property (@(posedge core_clk) disable iff (srst) // see RULE12
		s_read_cmd |=> s_read_done ##0 res_q == $past(cpu_reg_rdata))
		else $error("read result not captured");
	a_write_cmd: assert property (@(posedge core_clk) disable iff (srst) // see RULE14
		cmd_evt && wd >= CMD_WRITE_FIRST && wd <= CMD_WRITE_LAST
		|=> wr_q && cpu_reg_sel == $past(wd[2:0]) && cpu_reg_wdata == $past(wdat_q))
		else $error("write command wrong");
	a_long_set: assert property (@(posedge core_clk) disable iff (srst) // see RULE17
		cmd_evt && wd == CMD_SET_LONG |=> cpu_set_long_mode && !rd_q && !wr_q)
		else $error("set long mode missed");
	a_reserved_cmd: assert property (@(posedge core_clk) disable iff (srst) // see RULE20
		cmd_evt && wd > CMD_SET_LONG && wd != CMD_WRITE_FIRST && !(wd >= CMD_WRITE_FIRST && wd <= CMD_WRITE_LAST)
		|=> !rd_q && !wr_q && !setl_q ##1 res_q == $past(res_q))
		else $error("reserved command acted");
endmodule : dbc_debug_break

// *** dbc_link_master.sv ***
// ------------------------------------------------------------
// Framer model: writes bytes on the link, clock parked low.
// ------------------------------------------------------------
module dbc_link_master (
	output logic link_clk,
	output logic link_wr_en,
	output logic [6:0] link_wr_addr,
	output logic [7:0] link_wr_data
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle levels before the first frame.
	initial begin
		link_clk = 1'b0;
		link_wr_en = 1'b0;
		link_wr_addr = 7'h00;
		link_wr_data = 8'h00;
	end

	// Clock periods inside a frame; outside frames the clock stands still.
	task automatic idle(input int n);
		repeat (n) begin
			#24 link_clk = 1'b1;
			#24 link_clk = 1'b0;
		end
	endtask : idle

	// The gap comes first, so the caller can watch the effect of the byte.
	task automatic send(input logic [6:0] a, input logic [7:0] d);
		#23;
		idle(8);
		link_wr_addr = a;
		link_wr_data = d;
		link_wr_en = 1'b1;
		#24 link_clk = 1'b1;
		#1 link_wr_en = 1'b0;
		link_wr_addr = ~a; // Released lines do not keep the old value.
		link_wr_data = ~d;
		link_clk <= #23 1'b0;
	endtask : send
endmodule : dbc_link_master

// *** dbc_debug_break_tb_top.sv ***
module dbc_debug_break_tb_top
	import dbc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	logic core_clk, srst, link_clk, link_wr_en, debug_serial_clock_pin, debug_serial_data_pin;
	logic [6:0] link_wr_addr;
	logic [7:0] link_wr_data, memory_base_byte, read_result_upper, read_result_high, read_result_low;
	logic [23:0] cpu_addr, cpu_reg_rdata, cpu_reg_wdata;
	logic cpu_addr_valid, cpu_instr_start, cpu_instr_end, long_address_mode, cpu_halt;
	logic cpu_reg_rd, cpu_reg_wr, cpu_reg_long_sp, cpu_set_long_mode;
	logic [2:0] cpu_reg_sel;
	int fail_count, tests_run;

	// The CPU answers only while the read strobe is high, with a pattern that names the triple.
	assign cpu_reg_rdata = cpu_reg_rd ? {5'h15, cpu_reg_sel, 8'h3C, 5'h00, cpu_reg_sel} : 24'h000000;

	dbc_link_master i_dbc_link_master (.link_clk, .link_wr_en, .link_wr_addr, .link_wr_data);
	dbc_debug_break i_dbc_debug_break (.core_clk, .srst, .link_clk, .link_wr_en, .link_wr_addr,
		.link_wr_data, .debug_serial_clock_pin, .debug_serial_data_pin, .cpu_addr, .cpu_addr_valid,
		.cpu_instr_start, .cpu_instr_end, .long_address_mode, .memory_base_byte, .cpu_reg_rdata,
		.cpu_halt, .cpu_reg_rd, .cpu_reg_wr, .cpu_reg_sel, .cpu_reg_long_sp, .cpu_reg_wdata,
		.cpu_set_long_mode, .read_result_upper, .read_result_high, .read_result_low);

	// Core clock of 8 ns.
	initial core_clk = 1'b0;
	always #4 core_clk = ~core_clk;

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic summarize();
		if (fail_count == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : summarize

	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic send(input logic [6:0] a, input logic [7:0] d);
		i_dbc_link_master.send(a, d);
	endtask : send

	// Bounded wait for a pulse: 0 read, 1 write, 2 set long mode.
	task automatic wait_for(input int which, output logic seen);
		seen = 1'b0;
		for (int i = 0; i < 24 && seen !== 1'b1; i++) begin
			@(posedge core_clk);
			#1 seen = (which == 0) ? cpu_reg_rd : (which == 1) ? cpu_reg_wr : cpu_set_long_mode;
		end
		if (seen !== 1'b1) begin
			fail_count++;
			$display("mismatch pulse %0d expected 1 seen 0", which);
			summarize();
		end
	endtask : wait_for

	task automatic rd_cmd(input logic [7:0] c);
		logic seen;
		send(OFS_CPU_ACCESS_COMMAND, c);
		wait_for(0, seen);
		chk("read select", {21'h0, c[2:0]}, {21'h0, cpu_reg_sel});
		if (c == 8'h06) chk("read long sp", {23'h0, long_address_mode}, {23'h0, cpu_reg_long_sp});
		repeat (3) @(posedge core_clk);
		#1 chk("read result", {5'h15, c[2:0], 8'h3C, 5'h00, c[2:0]},
			{read_result_upper, read_result_high, read_result_low});
	endtask : rd_cmd

	// Data bytes and command go out as four ascending single-byte writes, each in its own frame.
	task automatic wr_cmd(input logic [7:0] c);
		logic seen;
		send(OFS_WRITE_DATA_UPPER, {5'h12, c[2:0]});
		send(OFS_WRITE_DATA_HIGH, 8'h41);
		send(OFS_WRITE_DATA_LOW, {5'h1C, c[2:0]});
		send(OFS_CPU_ACCESS_COMMAND, c);
		wait_for(1, seen);
		chk("write select", {21'h0, c[2:0]}, {21'h0, cpu_reg_sel});
		chk("write data", {5'h12, c[2:0], 8'h41, 5'h1C, c[2:0]}, cpu_reg_wdata);
		if (c == 8'h86) chk("write long sp", 24'h1, {23'h0, cpu_reg_long_sp});
	endtask : wr_cmd

	// A reserved code must produce no strobe and keep the result bytes.
	task automatic bad_cmd(input logic [7:0] c);
		logic [23:0] keep;
		keep = {read_result_upper, read_result_high, read_result_low};
		send(OFS_CPU_ACCESS_COMMAND, c);
		repeat (12) begin
			@(posedge core_clk);
			#1 chk("idle strobes", 24'h0, {21'h0, cpu_reg_rd, cpu_reg_wr, cpu_set_long_mode});
		end
		chk("result kept", keep, {read_result_upper, read_result_high, read_result_low});
	endtask : bad_cmd

	task automatic set_match(input logic [6:0] o, input logic [23:0] v);
		send(o, v[7:0]);
		send(o + 7'h01, v[15:8]);
		send(o + 7'h02, v[23:16]);
	endtask : set_match

	// One fetch under a given control byte; a non-start fetch must wait for the end.
	task automatic brk_case(input logic [7:0] ctl, input logic [23:0] a, input logic st, input logic exp);
		send(OFS_BREAK_CONTROL, ctl);
		repeat (6) @(posedge core_clk);
		cpu_addr <= a;
		cpu_addr_valid <= 1'b1;
		cpu_instr_start <= st;
		@(posedge core_clk);
		cpu_addr <= ~a;
		cpu_addr_valid <= 1'b0;
		cpu_instr_start <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 if (!st) chk("halt before end", 24'h0, {23'h0, cpu_halt});
		if (!st) begin
			@(posedge core_clk);
			cpu_instr_end <= 1'b1;
			@(posedge core_clk);
			cpu_instr_end <= 1'b0;
		end
		repeat (2) @(posedge core_clk);
		#1 chk("halt", {23'h0, exp}, {23'h0, cpu_halt});
		send(OFS_BREAK_CONTROL, 8'h00);
		repeat (6) @(posedge core_clk);
		#1 chk("halt released", 24'h0, {23'h0, cpu_halt});
	endtask : brk_case

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic seen;
		{fail_count, tests_run} = '0;
		{srst, debug_serial_clock_pin, debug_serial_data_pin} = 3'h4; // Strap pins low in reset.
		{cpu_addr, cpu_addr_valid, cpu_instr_start, cpu_instr_end} = '0;
		long_address_mode = 1'b1;
		memory_base_byte = 8'h00;
		repeat (3) @(posedge core_clk);
		i_dbc_link_master.idle(3); // Link side needs three edges inside reset to clear its toggle.
		@(posedge core_clk);
		srst <= 1'b0;
		{debug_serial_clock_pin, debug_serial_data_pin} <= 2'h3;
		repeat (2) @(posedge core_clk);
		#1 chk("strap halt", 24'h1, {23'h0, cpu_halt});
		brk_case(8'h80, 24'h000000, 1'b1, 1'b1);
		for (int c = 0; c < 8; c++) rd_cmd(c[7:0]);
		@(posedge core_clk) long_address_mode <= 1'b0;
		rd_cmd(8'h06);
		@(posedge core_clk) long_address_mode <= 1'b1;
		for (int c = 0; c < 8; c++) wr_cmd(8'h80 | c[7:0]);
		send(OFS_CPU_ACCESS_COMMAND, CMD_SET_LONG);
		wait_for(2, seen);
		bad_cmd(CMD_RESERVED_88);
		bad_cmd(8'h09);
		bad_cmd(8'hFF);
		set_match(7'h0C, 24'hABCDEF);
		brk_case(8'h40, 24'hABCDEF, 1'b1, 1'b1);
		brk_case(8'h40, 24'hABCDEF, 1'b0, 1'b1);
		brk_case(8'h40, 24'hABCDEE, 1'b1, 1'b0);
		set_match(7'h04, 24'h778800);
		brk_case(8'h10, 24'h7788F0, 1'b1, 1'b0);
		brk_case(8'h14, 24'h7788F0, 1'b1, 1'b1);
		set_match(7'h08, 24'h00A0B0);
		brk_case(8'h20, 24'h00A0B0, 1'b1, 1'b1);
		@(posedge core_clk);
		long_address_mode <= 1'b0;
		memory_base_byte <= 8'h12;
		set_match(7'h00, 24'h123456);
		brk_case(8'h08, 24'hFF3456, 1'b1, 1'b1);
		brk_case(8'h08, 24'h0034AB, 1'b1, 1'b0);
		brk_case(8'h0A, 24'h0034AB, 1'b1, 1'b1);
		brk_case(8'h01, 24'h000000, 1'b0, 1'b1);
		// Second reset with the strap pins high: no break, results cleared, link still alive.
		@(posedge core_clk) srst <= 1'b1;
		i_dbc_link_master.idle(3);
		@(posedge core_clk) srst <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 chk("no strap halt", 24'h0, {23'h0, cpu_halt});
		chk("reset result", 24'h0, {read_result_upper, read_result_high, read_result_low});
		rd_cmd(8'h07);
		summarize();
	end

	// Hang guard.
	initial begin
		#400000;
		fail_count++;
		summarize();
	end
endmodule : dbc_debug_break_tb_top
